// ===== pkg/smbma_defs.svh
`ifndef SMBMA_DEFS_SVH
`define SMBMA_DEFS_SVH
`define SMBMA_CMD_BLK_WR 8'hFC
`define SMBMA_CMD_BLK_RD 8'hFD
`define SMBMA_RAM_MAX 8'hDF
`define SMBMA_EE_HI_MIN 8'hF8
`define SMBMA_EE_HI_MAX 8'hFB
`define SMBMA_EE_BASE 16'hF800
`define SMBMA_EE_TOP 16'hFBFF
`define SMBMA_BLK_CNT 8'h20
`define SMBMA_BLK_LAST 6'h20
`define SMBMA_PEC_IDX 6'h21
`define SMBMA_CRC_POLY 8'h07
`define SMBMA_EE_PROG_US 250
`define SMBMA_CLK_MHZ 200
`define SMBMA_DEV_ADDR 7'h2A
`define SMBMA_FIFO_DEPTH 16
`endif

// ===== pkg/smbma_pkg.sv
package smbma_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_HOLD,
    ST_ACK,
    ST_TX,
    ST_TACK
  } smbma_state_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } smbma_wr_s;
endpackage

// ===== verilog/smbma_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "smbma_defs.svh"

module smbma_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count
  assign in_ready = count_reg != (AW+1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap freely; depth is a power of two
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

  // Storage has no reset
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

// Function
// R1 - Block write is address+write then command FC; both bytes are acknowledged.
// R2 - Host sets the start address beforehand by send byte or write byte.
// R3 - Host follows the block write command with a count of at most 32.
// R4 - Each block write data byte is acknowledged; host ends with stop.
// R5 - Block write may start anywhere; bytes past FBFF go to invalid addresses.
// R6 - Host erases every page a crossing block write touches.
// R7 - Each EEPROM byte programs in 250 us; SCL is held low meanwhile. The code holds SCL low while the 16-entry write queue is full and one clock after.
// R8 - Receive byte returns one byte from the set address, then NACK, stop.
// R9 - Block read is write FD, repeated start, address+read, all acknowledged.
// R10 - Host sets the start address before a block read.
// R11 - Block read sends count 0x20, then always 32 data bytes.
// R12 - Host acknowledges count and data bytes of a block read, ends with stop.
// R13 - Check byte is optional after single writes, block write, block read.
// R14 - Block read check byte follows the 32 data bytes; host NACKs, stops.
// R15 - Check byte is CRC-8 with polynomial x^8 + x^2 + x + 1.
// R16 - Valid targets are RAM 00..DF and EEPROM F800..FBFF.
// R17 - Write with command F8..FB plus low byte sets an EEPROM address.
// R18 - Send byte with a RAM address sets the start for later accesses.
// R19 - Access address steps by one after each block data byte.
// R20 - CRC starts at zero on start and covers every byte sent.
module smbma_top #(
  parameter int EE_PROG_CYC = `SMBMA_EE_PROG_US * `SMBMA_CLK_MHZ,
  parameter logic [6:0] DEV_ADDR = `SMBMA_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_n,
  output logic sda_o,
  output logic sda_oe_n,
  output logic ee_busy
);
  smbma_pkg::smbma_state_e state_reg;
  smbma_pkg::smbma_wr_s wr_in;
  smbma_pkg::smbma_wr_s wr_out;
  logic [7:0] ram [0:223];
  logic [7:0] eeprom [0:1023];
  logic scl_m;
  logic scl_s;
  logic scl_p;
  logic sda_m;
  logic sda_s;
  logic sda_p;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic [7:0] byte_idx;
  logic [5:0] tx_idx;
  logic rw_reg;
  logic nack_reg;
  logic [7:0] cmd_reg;
  logic [7:0] count_reg;
  logic blk_armed;
  logic [15:0] addr_reg;
  logic [7:0] crc_reg;
  logic [31:0] ee_timer;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic cmd_ee;
  logic push_req;
  logic in_ready;
  logic hold_go;
  logic tx_load;
  logic [7:0] mem_rd;
  logic [7:0] tx_byte;
  logic out_valid;
  logic out_ready;
  logic out_ram;
  logic out_ee;

  // One CRC-8 step over a whole byte, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++)
      r = r[7] ? {r[6:0], 1'b0} ^ `SMBMA_CRC_POLY : {r[6:0], 1'b0}; // R15
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  // Pins are asynchronous: two flops, then a third for edge finding
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  // Bus conditions seen from the synchronised levels
  assign start_det = scl_s && scl_p && sda_p && !sda_s;
  assign stop_det = scl_s && scl_p && !sda_p && sda_s;
  assign scl_rise = scl_s && !scl_p;
  assign scl_fall = !scl_s && scl_p;

  // Which received bytes must be stored
  assign cmd_ee = cmd_reg >= `SMBMA_EE_HI_MIN && cmd_reg <= `SMBMA_EE_HI_MAX;
  assign push_req = !rw_reg && (
    (byte_idx == 8'h02 && cmd_reg <= `SMBMA_RAM_MAX) ||
    (byte_idx == 8'h03 && cmd_ee) ||
    (cmd_reg == `SMBMA_CMD_BLK_WR && byte_idx >= 8'h03 &&
     {1'b0, byte_idx} < {1'b0, count_reg} + 9'h003)); // R4 R13
  assign hold_go = state_reg == smbma_pkg::ST_HOLD && (!push_req || in_ready);
  assign tx_load = scl_fall && ((state_reg == smbma_pkg::ST_ACK && rw_reg) ||
    (state_reg == smbma_pkg::ST_TACK && !nack_reg));

  // Read path; holes and out of range addresses read as all ones
  always_comb
  begin
    if (addr_reg <= {8'h00, `SMBMA_RAM_MAX})
      mem_rd = ram[addr_reg[7:0]];
    else if (addr_reg >= `SMBMA_EE_BASE && addr_reg <= `SMBMA_EE_TOP) // R16
      mem_rd = eeprom[addr_reg[9:0]];
    else
      mem_rd = 8'hFF;
    if (!blk_armed)
      tx_byte = mem_rd; // R8
    else if (tx_idx == 6'h00)
      tx_byte = `SMBMA_BLK_CNT; // R11
    else if (tx_idx <= `SMBMA_BLK_LAST)
      tx_byte = mem_rd; // R11
    else if (tx_idx == `SMBMA_PEC_IDX)
      tx_byte = crc_reg; // R14
    else
      tx_byte = 8'hFF;
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Bit and byte sequencing; stop and start abort whatever is in flight
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= smbma_pkg::ST_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      byte_idx <= 8'h00;
      tx_idx <= 6'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (stop_det)
    begin
      state_reg <= smbma_pkg::ST_IDLE;
      sda_oe_n <= 1'b1;
    end
    else if (start_det)
    begin
      state_reg <= smbma_pkg::ST_RX;
      bit_cnt <= 4'h0;
      byte_idx <= 8'h00;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        smbma_pkg::ST_IDLE:
          sda_oe_n <= 1'b1;
        smbma_pkg::ST_RX:
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (scl_fall && bit_cnt == 4'h8)
            state_reg <= smbma_pkg::ST_HOLD;
        smbma_pkg::ST_HOLD:
          if (hold_go)
          begin
            if (byte_idx != 8'hFF)
              byte_idx <= byte_idx + 8'h01;
            if (byte_idx == 8'h00 && shreg[7:1] != DEV_ADDR)
              state_reg <= smbma_pkg::ST_IDLE;
            else
            begin
              state_reg <= smbma_pkg::ST_ACK;
              sda_oe_n <= 1'b0; // R1 R4 R8 R9
            end
            if (byte_idx == 8'h00)
            begin
              rw_reg <= shreg[0];
              tx_idx <= 6'h00;
            end
          end
        smbma_pkg::ST_ACK:
          if (scl_fall)
          begin
            bit_cnt <= 4'h0;
            if (rw_reg)
            begin
              state_reg <= smbma_pkg::ST_TX;
              sda_oe_n <= tx_byte[7];
              shreg <= {tx_byte[6:0], 1'b0};
              if (tx_idx != 6'h3F)
                tx_idx <= tx_idx + 6'h01;
            end
            else
            begin
              state_reg <= smbma_pkg::ST_RX;
              sda_oe_n <= 1'b1;
            end
          end
        smbma_pkg::ST_TX:
          if (scl_rise)
            bit_cnt <= bit_cnt + 4'h1;
          else if (scl_fall && bit_cnt == 4'h8)
          begin
            state_reg <= smbma_pkg::ST_TACK;
            sda_oe_n <= 1'b1;
          end
          else if (scl_fall)
          begin
            sda_oe_n <= shreg[7];
            shreg <= {shreg[6:0], 1'b0};
          end
        smbma_pkg::ST_TACK:
          if (scl_rise)
            nack_reg <= sda_s;
          else if (scl_fall && nack_reg)
            state_reg <= smbma_pkg::ST_IDLE; // R8 R14
          else if (scl_fall)
          begin
            state_reg <= smbma_pkg::ST_TX;
            bit_cnt <= 4'h0;
            sda_oe_n <= tx_byte[7];
            shreg <= {tx_byte[6:0], 1'b0};
            if (tx_idx != 6'h3F)
              tx_idx <= tx_idx + 6'h01;
          end
      endcase
    end
  end

  // Command, count and block read arming
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_reg <= 8'h00;
      count_reg <= 8'h00;
      blk_armed <= 1'b0;
    end
    else if (stop_det)
      blk_armed <= 1'b0;
    else if (hold_go && !rw_reg && byte_idx == 8'h01)
    begin
      cmd_reg <= shreg;
      blk_armed <= shreg == `SMBMA_CMD_BLK_RD; // R9
    end
    else if (hold_go && byte_idx == 8'h02 && cmd_reg == `SMBMA_CMD_BLK_WR)
      count_reg <= shreg; // R3
  end

  // Access address: set by command bytes, stepped by block traffic
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      addr_reg <= 16'h0000;
    else if (hold_go && !rw_reg && byte_idx == 8'h01 && shreg <= `SMBMA_RAM_MAX)
      addr_reg <= {8'h00, shreg}; // R18
    else if (hold_go && !rw_reg && byte_idx == 8'h02 && cmd_ee)
      addr_reg <= {cmd_reg, shreg}; // R17
    else if (hold_go && push_req && cmd_reg == `SMBMA_CMD_BLK_WR)
      addr_reg <= addr_reg + 16'h0001; // R19 R5
    else if (tx_load && blk_armed && tx_idx != 6'h00 && tx_idx <= `SMBMA_BLK_LAST)
      addr_reg <= addr_reg + 16'h0001; // R19
  end

  // CRC spans a repeated start so a block read check covers both halves
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      crc_reg <= 8'h00;
    else if (start_det && !blk_armed)
      crc_reg <= 8'h00; // R20
    else if (hold_go)
      crc_reg <= crc8(crc_reg, shreg); // R20
    else if (tx_load)
      crc_reg <= crc8(crc_reg, tx_byte); // R20
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Write queue; a full queue holds the byte and stretches SCL
  assign wr_in.addr = addr_reg;
  assign wr_in.data = shreg;

  smbma_fifo #(
    .WIDTH($bits(smbma_pkg::smbma_wr_s)),
    .DEPTH(`SMBMA_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(wr_in),
    .in_valid(state_reg == smbma_pkg::ST_HOLD && push_req),
    .in_ready(in_ready),
    .out_data(wr_out),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );

  // RAM drains at once; EEPROM waits for the previous byte to program
  assign out_ram = wr_out.addr <= {8'h00, `SMBMA_RAM_MAX};
  assign out_ee = wr_out.addr >= `SMBMA_EE_BASE && wr_out.addr <= `SMBMA_EE_TOP;
  assign out_ready = !out_ee || ee_timer == 32'h0; // R7

  always_ff @(posedge clk)
  begin
    if (out_valid && out_ram)
      ram[wr_out.addr[7:0]] <= wr_out.data;
    if (out_valid && out_ee && ee_timer == 32'h0)
      eeprom[wr_out.addr[9:0]] <= wr_out.data; // R5 R16
  end

  // Programming timer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ee_timer <= 32'h0;
    else if (out_valid && out_ee && ee_timer == 32'h0)
      ee_timer <= 32'(EE_PROG_CYC); // R7
    else if (ee_timer != 32'h0)
      ee_timer <= ee_timer - 32'h1;
  end

  // Pin drivers; the line only ever pulls low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_oe_n <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      ee_busy <= 1'b0;
    end
    else
    begin
      // Hold SCL one clock past the freeing slot so the ack is set up before SCL rises
      scl_oe_n <= !(state_reg == smbma_pkg::ST_HOLD && push_req &&
        (!in_ready || !scl_oe_n)); // R7
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      ee_busy <= ee_timer != 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  a_ack_low: assert property (@(posedge clk) disable iff (!rst_n) // R4
    state_reg == smbma_pkg::ST_ACK |-> !sda_oe_n)
    else $error("ack not driven low");
  a_stretch_scl: assert property (@(posedge clk) disable iff (!rst_n) // R7
    state_reg == smbma_pkg::ST_HOLD && push_req && !in_ready |=> !scl_oe_n)
    else $error("scl not stretched while queue full");
  a_count_byte: assert property (@(posedge clk) disable iff (!rst_n) // R11
    tx_load && blk_armed && tx_idx == 6'h00 |-> tx_byte == 8'h20)
    else $error("block count not 0x20");
  a_addr_step: assert property (@(posedge clk) disable iff (!rst_n) // R19
    tx_load && blk_armed && tx_idx == 6'h05 |=> addr_reg == $past(addr_reg) + 16'h0001)
    else $error("block read address did not step");
  a_pec_send: assert property (@(posedge clk) disable iff (!rst_n) // R14
    tx_load && blk_armed && tx_idx == 6'h21 |=> sda_oe_n == $past(crc_reg[7]))
    else $error("check byte not sent after data");
  a_crc_clear: assert property (@(posedge clk) disable iff (!rst_n) // R20
    start_det && !blk_armed |=> crc_reg == 8'h00)
    else $error("crc not cleared on start");
  a_ee_addr: assert property (@(posedge clk) disable iff (!rst_n) // R17
    hold_go && !rw_reg && byte_idx == 8'h02 && cmd_ee
    |=> addr_reg == {$past(cmd_reg), $past(shreg)})
    else $error("eeprom address not loaded");
  a_prog_gap: assert property (@(posedge clk) disable iff (!rst_n) // R7
    out_valid && out_ee && ee_timer == 32'h0 |-> ##2 ee_busy ##1 ee_busy)
    else $error("eeprom programming gap missing");
endmodule
`default_nettype wire

// ===== sim/smbma_host.sv
`timescale 1ns/1ps
`default_nettype none

// Bus master model: moves its own pull-downs after each falling clk edge
module smbma_host (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic timed_out
);
  localparam int HALF = 8; // 8 clk low, 8 clk high: 80 ns link period

  initial
  begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    timed_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Release SCL, then wait out any stretch; bounded so a stuck line cannot hang the run
  task automatic scl_rise();
    int n;
    scl_pull = 1'b0;
    n = 0;
    while (scl !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20000)
      timed_out = 1'b1;
  endtask

  // One bit: data set mid-low, held through the whole high phase
  task automatic xfer_bit(input logic b, output logic r);
    tick(HALF / 2);
    sda_pull = ~b;
    tick(HALF / 2);
    scl_rise();
    tick(HALF / 2);
    r = sda;
    tick(HALF / 2);
    scl_pull = 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Byte and framing tasks, MSB first
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], r);
    xfer_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(~ack, r);
  endtask

  // Works from idle and as a repeated start after a byte
  task automatic start();
    tick(HALF / 2);
    sda_pull = 1'b0;
    tick(HALF / 2);
    scl_rise();
    tick(HALF);
    sda_pull = 1'b1;
    tick(HALF);
    scl_pull = 1'b1;
  endtask

  task automatic stop();
    tick(HALF / 2);
    sda_pull = 1'b1;
    tick(HALF / 2);
    scl_rise();
    tick(HALF);
    sda_pull = 1'b0;
    tick(HALF);
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "smbma_defs.svh"

module testbench;
  localparam int EE_CYC = 2000; // Long enough that an EEPROM burst fills the queue
  localparam logic [6:0] DEV = `SMBMA_DEV_ADDR;
  logic clk = 1'b0;
  logic rst_n;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, ee_busy;
  logic scl_pull, sda_pull, timed_out;
  logic scl, sda;
  logic saw_stretch = 1'b0;
  logic [7:0] crc;
  logic [7:0] ram_exp [0:255];
  logic [7:0] ee_exp [0:1023];
  int busy_cnt = 0;
  int num_errors = 0;
  int check_count = 0;
  int seed = 69987;

  always #2.5 clk = ~clk;

  // Open-drain wires with pull-ups: low when either party pulls
  assign scl = (scl_oe_n ? 1'b1 : scl_o) & ~scl_pull;
  assign sda = (sda_oe_n ? 1'b1 : sda_o) & ~sda_pull;

  smbma_top #(.EE_PROG_CYC(EE_CYC), .DEV_ADDR(DEV)) DUT (.clk(clk), .rst_n(rst_n),
    .scl_i(scl), .sda_i(sda), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .ee_busy(ee_busy));

  smbma_host h (.clk(clk), .scl(scl), .sda(sda), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .timed_out(timed_out));

  // Watch stretching and programming time
  always @(posedge clk)
  begin
    if (scl_oe_n === 1'b0)
      saw_stretch <= 1'b1;
    if (ee_busy === 1'b1)
      busy_cnt <= busy_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge timed_out)
  begin
    num_errors++;
    wrap_up();
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // CRC-8, x^8 + x^2 + x + 1, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++)
      x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
    return x;
  endfunction

  // Out-of-range targets read back as FF
  function automatic logic [7:0] want(input logic [15:0] a);
    if (a <= 16'h00DF)
      return ram_exp[a[7:0]];
    if (a >= 16'hF800 && a <= 16'hFBFF)
      return ee_exp[a[9:0]];
    return 8'hFF;
  endfunction

  function automatic void put(input logic [15:0] a, input logic [7:0] d);
    if (a <= 16'h00DF)
      ram_exp[a[7:0]] = d;
    else if (a >= 16'hF800 && a <= 16'hFBFF)
      ee_exp[a[9:0]] = d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Every byte the bench sends must be acknowledged
  task automatic send(input logic [7:0] d);
    logic a;
    crc = crc8(crc, d);
    h.wr_byte(d, a);
    check({7'h00, a}, 8'h01);
  endtask

  task automatic recv(input logic ack, output logic [7:0] d);
    h.rd_byte(ack, d);
    crc = crc8(crc, d);
  endtask

  task automatic beg();
    crc = 8'h00;
    h.start();
  endtask

  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo, input logic ee);
    beg();
    send({DEV, 1'b0});
    send(hi);
    if (ee)
      send(lo);
    h.stop();
  endtask

  task automatic blk_wr(input logic [15:0] base, input logic [7:0] n);
    logic [7:0] d;
    beg();
    send({DEV, 1'b0});
    send(`SMBMA_CMD_BLK_WR);
    send(n);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      put(base + 16'(i), d);
      send(d);
    end
    send(crc);
    h.stop();
  endtask

  task automatic blk_rd(input logic [15:0] base);
    logic [7:0] d;
    logic [7:0] e;
    beg();
    send({DEV, 1'b0});
    send(`SMBMA_CMD_BLK_RD);
    h.start();
    send({DEV, 1'b1});
    recv(1'b1, d);
    check(d, 8'h20);
    for (int i = 0; i < 32; i++)
    begin
      recv(1'b1, d);
      check(d, want(base + 16'(i)));
    end
    e = crc;
    recv(1'b0, d);
    check(d, e);
    h.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic a;
    logic [7:0] d;
    logic [7:0] rb;
    int idle;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check({5'h00, scl_oe_n, sda_oe_n, ee_busy}, 8'h06);
    repeat (8) @(negedge clk);
    // A foreign address gets no acknowledge
    h.start();
    h.wr_byte({DEV ^ 7'h01, 1'b0}, a);
    check({7'h00, a}, 8'h00);
    h.stop();
    // Full RAM block at a random base, then a single write at the top of RAM
    rb = 8'($random(seed)) & 8'h7F;
    set_addr(rb, 8'h00, 1'b0);
    blk_wr({8'h00, rb}, 8'h20);
    d = 8'($random(seed));
    beg();
    send({DEV, 1'b0});
    send(8'hDF);
    send(d);
    send(crc);
    h.stop();
    put(16'h00DF, d);
    // Two receive bytes per address: the address must not step
    for (int i = 0; i < 4; i++)
    begin
      if (i % 2 == 0)
        set_addr(i == 0 ? rb + 8'h05 : 8'hDF, 8'h00, 1'b0);
      beg();
      send({DEV, 1'b1});
      recv(1'b0, d);
      check(d, want(i < 2 ? {8'h00, rb + 8'h05} : 16'h00DF));
      h.stop();
    end
    set_addr(rb, 8'h00, 1'b0);
    blk_rd({8'h00, rb});
    // EEPROM burst over the top: 24 bytes land, 8 fall off the end
    set_addr(8'hFB, 8'hE8, 1'b1);
    blk_wr(16'hFBE8, 8'h20);
    idle = 0;
    for (int n = 0; n < 80000 && idle < 10; n++)
    begin
      @(negedge clk);
      idle = (ee_busy === 1'b0) ? idle + 1 : 0;
    end
    check({7'h00, idle >= 10}, 8'h01);
    if (idle < 10)
      wrap_up();
    check({7'h00, saw_stretch}, 8'h01);
    check({7'h00, busy_cnt >= 24 * EE_CYC && busy_cnt <= 24 * EE_CYC + 48}, 8'h01);
    // Single EEPROM write with a check byte, then a receive byte from it
    rb = 8'($random(seed));
    d = 8'($random(seed));
    beg();
    send({DEV, 1'b0});
    send(8'hF8);
    send(rb);
    send(d);
    send(crc);
    h.stop();
    put({8'hF8, rb}, d);
    set_addr(8'hF8, rb, 1'b1);
    beg();
    send({DEV, 1'b1});
    recv(1'b0, d);
    check(d, want({8'hF8, rb}));
    h.stop();
    set_addr(8'hFB, 8'hE8, 1'b1);
    blk_rd(16'hFBE8);
    wrap_up();
  end
endmodule
`default_nettype wire
